/* include/art_pkg.sv */
// Constants, register map and carrier types of the PWM auto-reload timer
package art_pkg;
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    localparam int IDX_W = 10;
    localparam int NCH = 4;
    localparam int NCAP = 2;

    // Register indexes; byte address is four times the index
    localparam logic [IDX_W-1:0] IDX_DUTY3 = 10'h073;
    localparam logic [IDX_W-1:0] IDX_DUTY2 = 10'h074;
    localparam logic [IDX_W-1:0] IDX_DUTY1 = 10'h075;
    localparam logic [IDX_W-1:0] IDX_DUTY0 = 10'h076;
    localparam logic [IDX_W-1:0] IDX_PWM_OUTPUT_CONTROL = 10'h077;
    localparam logic [IDX_W-1:0] IDX_CSR = 10'h078;
    localparam logic [IDX_W-1:0] IDX_CAR = 10'h079;
    localparam logic [IDX_W-1:0] IDX_ARR = 10'h07a;
    localparam logic [IDX_W-1:0] IDX_CCSR = 10'h07b;
    localparam logic [IDX_W-1:0] IDX_ICR1 = 10'h07c;
    localparam logic [IDX_W-1:0] IDX_ICR2 = 10'h07d;

    // Field positions
    localparam int CSR_EXT_CLOCK_SELECT = 7;
    localparam int CSR_CC_LSB = 4;
    localparam int CSR_RUN = 3;
    localparam int CSR_FORCE_RELOAD = 2;
    localparam int CSR_OIE = 1;
    localparam int CSR_OVF = 0;
    localparam int PWM_OUTPUT_CONTROL_OE_LSB = 4;
    localparam int PWM_OUTPUT_CONTROL_OP_LSB = 0;
    localparam int CCSR_CS_LSB = 4;
    localparam int CCSR_CIE_LSB = 2;
    localparam int CCSR_CF_LSB = 0;

    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [7:0] CNT_TOP = 8'hff;
    localparam logic [6:0] PRESC_ONE = 7'h01;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic [ADDR_W-1:0] awaddr;
        logic awvalid;
        logic [DATA_W-1:0] wdata;
        logic [3:0] wstrb;
        logic wvalid;
        logic bready;
        logic [ADDR_W-1:0] araddr;
        logic arvalid;
        logic rready;
    } axil_req_t;

    typedef struct packed {
        logic awready;
        logic wready;
        logic [1:0] bresp;
        logic bvalid;
        logic arready;
        logic [DATA_W-1:0] rdata;
        logic [1:0] rresp;
        logic rvalid;
    } axil_rsp_t;
endpackage

/* rtl/pwm_auto_reload_timer.sv */
// PWM auto-reload timer with capture channels and an AXI4-Lite register bank
// Operation
// - Overflow sets flag; enabled flag raises interrupt
// - Flag cleared only by status register read
// - Event mode overflows after 256 minus reload
// - Capture edge copies counter, sets capture flag
// - Edge select bit picks rising or falling
// - Per-channel capture interrupt enable
// - Capture register locked until read clears flag
// - Flag and enable keep capture request pending
// - Capture edges double as wake interrupts; no wake path here, capture_irq only updates while clk_en is high
// - Bit 7 selects CPU or external clock
// - Divide field sets power-of-two prescale
// - Run bit low freezes prescaler and counter
// - Force reload loads counter, clears prescaler
// - Overflow interrupt enable gates request
// - Overflow is the step from FFh
// - Counter register reads live, writes counter
// - Overflow reloads counter and flips PWM levels
// - Output enables connect each PWM pin
// - Level high while counter at most compare
// - Polarity change inverts output at once
// - Duty register sets second PWM edge
// - Compare shadows load only at overflow
// - Counter steps on each prescaler tick
// - Counter write also clears prescaler
//
// Decided for this implementation: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module pwm_auto_reload_timer #(
    parameter int NUM_PWM = art_pkg::NCH,
    parameter int NUM_CAP = art_pkg::NCAP
) (
    // Clock, reset, enable
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic clk_en,
    // Register bus
    input wire art_pkg::axil_req_t axi_req,
    output var art_pkg::axil_rsp_t axi_rsp,
    // Pins
    input wire logic external_event_clock,
    input wire logic [NUM_CAP-1:0] capture_input_pin,
    output logic [NUM_PWM-1:0] pwm_channel_output,
    // Interrupt requests
    output logic overflow_irq,
    output logic [NUM_CAP-1:0] capture_irq
);
    typedef struct packed {
        logic aw_rdy;
        logic w_rdy;
        logic [art_pkg::IDX_W-1:0] aw_idx;
        logic [7:0] w_data;
        logic w_lane0;
        logic bvalid;
        logic [1:0] bresp;
        logic ar_rdy;
        logic rvalid;
        logic [7:0] rdata;
        logic [1:0] rresp;
        logic ext_prev;
        logic [NUM_CAP-1:0] cap_prev;
        logic [6:0] presc;
        logic [7:0] cnt;
        logic [7:0] reload;
        logic ext_clock_select;
        logic [2:0] cc;
        logic run;
        logic overflow_irq_enable;
        logic ovf;
        logic [NUM_PWM-1:0] oe;
        logic [NUM_PWM-1:0] pol;
        logic [NUM_PWM-1:0][7:0] duty;
        logic [NUM_PWM-1:0][7:0] cmp;
        logic [NUM_CAP-1:0] cs;
        logic [NUM_CAP-1:0] cie;
        logic [NUM_CAP-1:0] cf;
        logic [NUM_CAP-1:0][7:0] icr;
        logic [NUM_PWM-1:0] pwm;
        logic ovf_irq;
        logic [NUM_CAP-1:0] cap_irq;
    } state_t;

    state_t s_reg;
    state_t s_next;

    logic aw_hs;
    logic w_hs;
    logic do_wr;
    logic ar_hs;
    logic [art_pkg::IDX_W-1:0] ar_idx;
    logic [art_pkg::IDX_W-1:0] wr_idx;
    logic [7:0] wr_byte;
    logic in_tick;
    logic [6:0] tap_mask;
    logic cnt_tick;
    logic ovf_evt;
    logic csr_rd;
    logic csr_wr;
    logic force_reload;
    logic cnt_wr;
    logic [NUM_CAP-1:0] icr_rd;
    logic [NUM_CAP-1:0] cap_evt;

    assign aw_hs = axi_req.awvalid && s_reg.aw_rdy;
    assign w_hs = axi_req.wvalid && s_reg.w_rdy;
    assign ar_hs = axi_req.arvalid && s_reg.ar_rdy;
    assign ar_idx = axi_req.araddr[art_pkg::ADDR_W-1:2];
    // Write fires once both halves are held, either arriving first
    assign do_wr = (!s_reg.aw_rdy || aw_hs) && (!s_reg.w_rdy || w_hs)
        && !s_reg.bvalid;
    assign wr_idx = s_reg.aw_rdy ? axi_req.awaddr[art_pkg::ADDR_W-1:2]
        : s_reg.aw_idx;
    assign wr_byte = s_reg.w_rdy ? axi_req.wdata[7:0] : s_reg.w_data;
    assign csr_wr = do_wr && (wr_idx == art_pkg::IDX_CSR);
    assign cnt_wr = do_wr && (wr_idx == art_pkg::IDX_CAR);
    assign force_reload = csr_wr && wr_byte[art_pkg::CSR_FORCE_RELOAD];
    assign csr_rd = ar_hs && (ar_idx == art_pkg::IDX_CSR);
    assign icr_rd[0] = ar_hs && (ar_idx == art_pkg::IDX_ICR1);
    assign icr_rd[1] = ar_hs && (ar_idx == art_pkg::IDX_ICR2);

    // External clock sampled on the bus clock; it must run slower than half of aclk
    assign in_tick = s_reg.ext_clock_select ? (external_event_clock && !s_reg.ext_prev)
        : 1'b1;
    assign tap_mask = 7'((8'h01 << s_reg.cc) - 8'h01);
    assign cnt_tick = s_reg.run && in_tick
        && ((s_reg.presc & tap_mask) == tap_mask);
    assign ovf_evt = cnt_tick && (s_reg.cnt == art_pkg::CNT_TOP);

    genvar g;
    generate
        for (g = 0; g < NUM_CAP; g++) begin : g_cap
            assign cap_evt[g] = !s_reg.cf[g] && (s_reg.cs[g]
                ? (capture_input_pin[g] && !s_reg.cap_prev[g])
                : (!capture_input_pin[g] && s_reg.cap_prev[g]));
        end
    endgenerate

    always_comb begin
        logic [7:0] rd;
        logic [1:0] ch;
        rd = art_pkg::RST_BYTE;
        ch = 2'h0;
        s_next = s_reg;
        s_next.ext_prev = external_event_clock;
        s_next.cap_prev = capture_input_pin;

        // Bus handshakes
        if (aw_hs) begin
            s_next.aw_rdy = 1'b0;
            s_next.aw_idx = axi_req.awaddr[art_pkg::ADDR_W-1:2];
        end
        if (w_hs) begin
            s_next.w_rdy = 1'b0;
            s_next.w_data = axi_req.wdata[7:0];
            s_next.w_lane0 = axi_req.wstrb[0];
        end
        if (s_reg.bvalid && axi_req.bready) begin
            s_next.bvalid = 1'b0;
            s_next.aw_rdy = 1'b1;
            s_next.w_rdy = 1'b1;
        end
        if (s_reg.rvalid && axi_req.rready) begin
            s_next.rvalid = 1'b0;
            s_next.ar_rdy = 1'b1;
        end

        // Prescaler and counter
        if (s_reg.run && in_tick) begin
            s_next.presc = s_reg.presc + art_pkg::PRESC_ONE;
        end
        if (cnt_tick) begin
            if (ovf_evt) begin
                s_next.cnt = s_reg.reload;
                s_next.cmp = s_reg.duty;
            end else begin
                s_next.cnt = s_reg.cnt + 8'h01;
            end
        end
        // Clearing read loses to a new overflow
        s_next.ovf = (s_reg.ovf && !csr_rd) || ovf_evt;

        // Captures: set beats the clearing read
        for (int i = 0; i < NUM_CAP; i++) begin
            if (icr_rd[i]) begin
                s_next.cf[i] = 1'b0;
            end
            if (cap_evt[i]) begin
                s_next.icr[i] = s_reg.cnt;
                s_next.cf[i] = 1'b1;
            end
        end

        // Register write
        if (do_wr) begin
            s_next.bvalid = 1'b1;
            s_next.bresp = art_pkg::RESP_OKAY;
            if (wr_idx >= art_pkg::IDX_DUTY3
                    && wr_idx <= art_pkg::IDX_DUTY0) begin
                ch = 2'(art_pkg::IDX_DUTY0 - wr_idx);
                if (s_next.w_lane0 || (w_hs && axi_req.wstrb[0])) begin
                    s_next.duty[ch] = wr_byte;
                end
            end else if (wr_idx == art_pkg::IDX_PWM_OUTPUT_CONTROL) begin
                if (s_next.w_lane0) begin
                    s_next.oe = wr_byte[art_pkg::PWM_OUTPUT_CONTROL_OE_LSB +: NUM_PWM];
                    s_next.pol = wr_byte[art_pkg::PWM_OUTPUT_CONTROL_OP_LSB +: NUM_PWM];
                end
            end else if (wr_idx == art_pkg::IDX_CSR) begin
                if (s_next.w_lane0) begin
                    s_next.ext_clock_select = wr_byte[art_pkg::CSR_EXT_CLOCK_SELECT];
                    s_next.cc = wr_byte[art_pkg::CSR_CC_LSB +: 3];
                    s_next.run = wr_byte[art_pkg::CSR_RUN];
                    s_next.overflow_irq_enable = wr_byte[art_pkg::CSR_OIE];
                    if (wr_byte[art_pkg::CSR_FORCE_RELOAD]) begin
                        s_next.cnt = s_reg.reload;
                        s_next.presc = 7'h00;
                    end
                end
            end else if (wr_idx == art_pkg::IDX_CAR) begin
                if (s_next.w_lane0) begin
                    s_next.cnt = wr_byte;
                    s_next.presc = 7'h00;
                end
            end else if (wr_idx == art_pkg::IDX_ARR) begin
                if (s_next.w_lane0) begin
                    s_next.reload = wr_byte;
                end
            end else if (wr_idx == art_pkg::IDX_CCSR) begin
                if (s_next.w_lane0) begin
                    s_next.cs = wr_byte[art_pkg::CCSR_CS_LSB +: NUM_CAP];
                    s_next.cie = wr_byte[art_pkg::CCSR_CIE_LSB +: NUM_CAP];
                end
            end else if (wr_idx == art_pkg::IDX_ICR1
                    || wr_idx == art_pkg::IDX_ICR2) begin
                s_next.bresp = art_pkg::RESP_OKAY;
            end else begin
                s_next.bresp = art_pkg::RESP_SLVERR;
            end
        end

        // Register read
        if (ar_hs) begin
            s_next.ar_rdy = 1'b0;
            s_next.rvalid = 1'b1;
            s_next.rresp = art_pkg::RESP_OKAY;
            if (ar_idx >= art_pkg::IDX_DUTY3
                    && ar_idx <= art_pkg::IDX_DUTY0) begin
                rd = s_reg.duty[2'(art_pkg::IDX_DUTY0 - ar_idx)];
            end else if (ar_idx == art_pkg::IDX_PWM_OUTPUT_CONTROL) begin
                rd = {s_reg.oe, s_reg.pol};
            end else if (ar_idx == art_pkg::IDX_CSR) begin
                // Force-reload bit always reads zero
                rd = {s_reg.ext_clock_select, s_reg.cc, s_reg.run, 1'b0, s_reg.overflow_irq_enable,
                    s_reg.ovf};
            end else if (ar_idx == art_pkg::IDX_CAR) begin
                rd = s_reg.cnt;
            end else if (ar_idx == art_pkg::IDX_ARR) begin
                rd = s_reg.reload;
            end else if (ar_idx == art_pkg::IDX_CCSR) begin
                rd = {2'h0, s_reg.cs, s_reg.cie, s_reg.cf};
            end else if (ar_idx == art_pkg::IDX_ICR1) begin
                rd = s_reg.icr[0];
            end else if (ar_idx == art_pkg::IDX_ICR2) begin
                rd = s_reg.icr[1];
            end else begin
                s_next.rresp = art_pkg::RESP_SLVERR;
            end
            s_next.rdata = rd;
        end

        // Registered pin and request levels from the next state
        for (int i = 0; i < NUM_PWM; i++) begin
            s_next.pwm[i] = s_next.oe[i] && ((s_next.cnt <= s_next.cmp[i])
                ^ s_next.pol[i]);
        end
        s_next.ovf_irq = s_next.ovf && s_next.overflow_irq_enable;
        s_next.cap_irq = s_next.cf & s_next.cie;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_reg <= '0;
            s_reg.aw_rdy <= 1'b1;
            s_reg.w_rdy <= 1'b1;
            s_reg.ar_rdy <= 1'b1;
        end else if (clk_en) begin
            s_reg <= s_next;
        end
    end

    assign axi_rsp.awready = s_reg.aw_rdy;
    assign axi_rsp.wready = s_reg.w_rdy;
    assign axi_rsp.bresp = s_reg.bresp;
    assign axi_rsp.bvalid = s_reg.bvalid;
    assign axi_rsp.arready = s_reg.ar_rdy;
    assign axi_rsp.rdata = {24'h000000, s_reg.rdata};
    assign axi_rsp.rresp = s_reg.rresp;
    assign axi_rsp.rvalid = s_reg.rvalid;
    assign pwm_channel_output = s_reg.pwm;
    assign overflow_irq = s_reg.ovf_irq;
    assign capture_irq = s_reg.cap_irq;

    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    AST_OVF_SET: assert property ((clk_en && ovf_evt) |=> s_reg.ovf)
        else $error("overflow did not set flag");
    AST_OVF_HOLD: assert property (
        (s_reg.ovf && !(clk_en && csr_rd)) |=> s_reg.ovf)
        else $error("overflow flag lost without status read");
    AST_OVF_RACE: assert property (
        (clk_en && csr_rd && ovf_evt) |=> s_reg.ovf)
        else $error("overflow lost to clearing read");
    AST_OVF_IRQ: assert property (
        (clk_en && ovf_evt && s_reg.overflow_irq_enable && !csr_wr) |=> overflow_irq)
        else $error("enabled overflow gave no request");
    AST_RELOAD: assert property (
        (clk_en && ovf_evt && !cnt_wr && !force_reload)
        |=> s_reg.cnt == $past(s_reg.reload))
        else $error("overflow did not reload counter");
    AST_FREEZE: assert property (
        (clk_en && !s_reg.run && !cnt_wr && !force_reload)
        |=> $stable(s_reg.cnt) && $stable(s_reg.presc))
        else $error("stopped counter moved");
    AST_FORCE: assert property ((clk_en && force_reload) |=>
        s_reg.cnt == $past(s_reg.reload) && s_reg.presc == 7'h00)
        else $error("force reload failed");
    AST_CAP: assert property ((clk_en && cap_evt[0]) |=>
        s_reg.cf[0] && s_reg.icr[0] == $past(s_reg.cnt))
        else $error("capture did not latch counter");
    AST_CAP_LOCK: assert property (
        (s_reg.cf[1] && !(clk_en && icr_rd[1]))
        |=> $stable(s_reg.icr[1]) && s_reg.cf[1])
        else $error("locked capture register changed");
    AST_CAP_IRQ: assert property (
        (clk_en && cap_evt[0] && s_reg.cie[0] && !do_wr)
        |=> capture_irq[0])
        else $error("capture request not pending");
    AST_PWM0: assert property (pwm_channel_output[0] ==
        (s_reg.oe[0] && ((s_reg.cnt <= s_reg.cmp[0]) ^ s_reg.pol[0])))
        else $error("PWM level wrong");

    COV_OVF: cover property (clk_en && ovf_evt && s_reg.overflow_irq_enable);
    COV_RACE: cover property (clk_en && csr_rd && ovf_evt);
    COV_CAP: cover property (clk_en && cap_evt[0] ##[1:20] icr_rd[0]);
    COV_FREEZE: cover property (!clk_en && s_reg.run);
endmodule
`default_nettype wire

/* test/art_far_end.sv */
// Far-side model: event clock source, capture pins and PWM loads
`timescale 1ns/1ps
`default_nettype none
module art_far_end (
    // Clock
    input wire logic aclk,
    // Pins
    output logic ext_clk,
    output logic [1:0] cap_pin,
    input wire logic [3:0] pwm_load
);
    initial begin
        ext_clk = 1'b0;
        cap_pin = 2'b00;
    end
    // Two cycles high and three low, slower than half the bus clock
    task automatic pulse_events(input int n);
        repeat (n) begin
            @(posedge aclk);
            ext_clk <= 1'b1;
            repeat (2) @(posedge aclk);
            ext_clk <= 1'b0;
            repeat (2) @(posedge aclk);
        end
    endtask
    // Extra edges let sampling, capture and request registers settle
    task automatic set_pin(input int ch, input logic v);
        @(posedge aclk);
        cap_pin[ch] <= v;
        repeat (4) @(posedge aclk);
    endtask
endmodule
`default_nettype wire

/* test/pwm_auto_reload_timer_tb.sv */
// Self-checking bench of the PWM auto-reload timer
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) \
    n_compared++; \
    if ((g) !== (e)) begin \
        n_fail++; \
        $display("MISMATCH %s exp %h got %h", nm, e, g); \
    end
module pwm_auto_reload_timer_tb;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic clk_en = 1'b1;
    art_pkg::axil_req_t req;
    art_pkg::axil_rsp_t rsp;
    logic ext_clk;
    logic [1:0] cap_pin;
    logic [3:0] pwm;
    logic ovf_irq;
    logic [1:0] cap_irq;
    logic [9:0] expq[$];
    logic [9:0] exp_r;
    logic [1:0] expb[$];
    logic [1:0] exp_b;
    logic [31:0] lfsr = 32'h0000_05b3;
    int n_fail = 0;
    int n_compared = 0;

    always #2 aclk = ~aclk;

    pwm_auto_reload_timer dut (.aclk(aclk), .aresetn(aresetn),
        .clk_en(clk_en), .axi_req(req), .axi_rsp(rsp),
        .external_event_clock(ext_clk), .capture_input_pin(cap_pin),
        .pwm_channel_output(pwm), .overflow_irq(ovf_irq),
        .capture_irq(cap_irq));
    art_far_end far (.aclk(aclk), .ext_clk(ext_clk), .cap_pin(cap_pin),
        .pwm_load(pwm));

    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    // Read results against the oldest expectation
    always @(posedge aclk) begin
        if (rsp.rvalid && req.rready) begin
            exp_r = expq.pop_front();
            `CHK("read", exp_r, {rsp.rresp, rsp.rdata[7:0]})
        end
        if (rsp.bvalid && req.bready) begin
            exp_b = expb.pop_front();
            `CHK("bresp", exp_b, rsp.bresp)
        end
    end

    task automatic wr(input logic [9:0] idx, input logic [7:0] d,
                      input logic [3:0] st = 4'h1,
                      input logic [1:0] br = art_pkg::RESP_OKAY);
        logic aw;
        logic w;
        aw = 1'b1;
        w = 1'b1;
        expb.push_back(br);
        req.awaddr <= {idx, 2'b00};
        req.awvalid <= 1'b1;
        req.wdata <= {24'h00_0000, d};
        req.wstrb <= st;
        req.wvalid <= 1'b1;
        while (aw || w) begin
            @(posedge aclk);
            if (aw && rsp.awready) begin
                aw = 1'b0;
                req.awvalid <= 1'b0;
            end
            if (w && rsp.wready) begin
                w = 1'b0;
                req.wvalid <= 1'b0;
            end
        end
        do @(posedge aclk); while (!rsp.bvalid);
        @(posedge aclk);
    endtask

    task automatic rd(input logic [9:0] idx, input logic [7:0] d,
                      input logic [1:0] r = art_pkg::RESP_OKAY);
        req.araddr <= {idx, 2'b00};
        req.arvalid <= 1'b1;
        expq.push_back({r, d});
        do @(posedge aclk); while (!rsp.arready);
        req.arvalid <= 1'b0;
        do @(posedge aclk); while (!rsp.rvalid);
        @(posedge aclk);
    endtask

    task automatic close_out();
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    initial begin
        repeat (5000) @(posedge aclk);
        n_fail++;
        close_out();
    end

    initial begin
        req = '0;
        req.bready = 1'b1;
        req.rready = 1'b1;
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rd(art_pkg::IDX_CSR, 8'h00);
        rd(art_pkg::IDX_PWM_OUTPUT_CONTROL, 8'h00);
        rd(art_pkg::IDX_DUTY0, 8'h00);
        rd(10'h000, 8'h00, art_pkg::RESP_SLVERR);
        repeat (4) begin
            lfsr = lfsr_next(lfsr);
            wr(art_pkg::IDX_CAR, lfsr[7:0]);
            rd(art_pkg::IDX_CAR, lfsr[7:0]);
        end
        // Lane 0 strobe low leaves the counter alone
        wr(art_pkg::IDX_CAR, 8'h77, 4'h0);
        rd(art_pkg::IDX_CAR, lfsr[7:0]);
        wr(10'h000, 8'hff, 4'h1, art_pkg::RESP_SLVERR);
        $display("test registers done");
        wr(art_pkg::IDX_CAR, 8'hfd);
        wr(art_pkg::IDX_CSR, 8'h08);
        // Read lands on the overflow edge; the flag must survive it
        rd(art_pkg::IDX_CSR, 8'h08);
        `CHK("ovf_irq masked", 1'b0, ovf_irq)
        wr(art_pkg::IDX_CSR, 8'h02);
        `CHK("ovf_irq on", 1'b1, ovf_irq)
        rd(art_pkg::IDX_CSR, 8'h03);
        rd(art_pkg::IDX_CSR, 8'h02);
        `CHK("ovf_irq cleared", 1'b0, ovf_irq)
        $display("test overflow done");
        wr(art_pkg::IDX_ARR, 8'hfd);
        wr(art_pkg::IDX_CSR, 8'h84);
        rd(art_pkg::IDX_CSR, 8'h80);
        rd(art_pkg::IDX_CAR, 8'hfd);
        wr(art_pkg::IDX_CSR, 8'h8a);
        far.pulse_events(2);
        rd(art_pkg::IDX_CSR, 8'h8a);
        far.pulse_events(1);
        `CHK("ovf_irq event", 1'b1, ovf_irq)
        rd(art_pkg::IDX_CSR, 8'h8b);
        rd(art_pkg::IDX_CAR, 8'hfd);
        wr(art_pkg::IDX_CSR, 8'h94);
        wr(art_pkg::IDX_CSR, 8'h98);
        far.pulse_events(4);
        rd(art_pkg::IDX_CSR, 8'h98);
        far.pulse_events(2);
        rd(art_pkg::IDX_CSR, 8'h99);
        $display("test event mode done");
        wr(art_pkg::IDX_CSR, 8'h00);
        wr(art_pkg::IDX_CAR, 8'h42);
        wr(art_pkg::IDX_CCSR, 8'h14);
        far.set_pin(0, 1'b1);
        `CHK("cap_irq set", 2'b01, cap_irq)
        wr(art_pkg::IDX_CAR, 8'h55);
        far.set_pin(0, 1'b0);
        far.set_pin(0, 1'b1);
        rd(art_pkg::IDX_ICR1, 8'h42);
        `CHK("cap_irq cleared", 2'b00, cap_irq)
        far.set_pin(1, 1'b1);
        wr(art_pkg::IDX_CAR, 8'h66);
        far.set_pin(1, 1'b0);
        rd(art_pkg::IDX_CCSR, 8'h16);
        `CHK("cap_irq masked", 2'b00, cap_irq)
        rd(art_pkg::IDX_ICR2, 8'h66);
        $display("test capture done");
        wr(art_pkg::IDX_CAR, 8'h00);
        wr(art_pkg::IDX_PWM_OUTPUT_CONTROL, 8'h30);
        `CHK("pwm enable", 4'b0011, pwm)
        wr(art_pkg::IDX_PWM_OUTPUT_CONTROL, 8'h31);
        `CHK("pwm polarity", 4'b0010, pwm)
        wr(art_pkg::IDX_DUTY0, 8'h80);
        wr(art_pkg::IDX_DUTY1, 8'h80);
        wr(art_pkg::IDX_CAR, 8'h10);
        `CHK("pwm old compare", 4'b0001, pwm)
        wr(art_pkg::IDX_ARR, 8'h00);
        wr(art_pkg::IDX_CAR, 8'hff);
        wr(art_pkg::IDX_CSR, 8'h88);
        far.pulse_events(1);
        wr(art_pkg::IDX_CSR, 8'h00);
        `CHK("pwm new compare", 4'b0010, pwm)
        rd(art_pkg::IDX_CAR, 8'h00);
        $display("test pwm done");
        // Two steps run, ten edges frozen, one step on the stopping write
        wr(art_pkg::IDX_CAR, 8'h20);
        wr(art_pkg::IDX_CSR, 8'h08);
        clk_en <= 1'b0;
        repeat (10) @(posedge aclk);
        clk_en <= 1'b1;
        wr(art_pkg::IDX_CSR, 8'h00);
        rd(art_pkg::IDX_CAR, 8'h23);
        $display("test freeze done");
        close_out();
    end
endmodule
`default_nettype wire
